// ==== core/drive_control_status_words.sv ====
// Command word decoder, status word builder and speed reference selection for the drive's bus interface.
`timescale 1ns/1ps
// Function
// [RULE_01] During frequency hold, only coast, DC brake or matching digital inputs stop.
// [RULE_02] Bit 06 low ramps to stop; high permits start gated by start source.
// [RULE_03] Bit 07 clears a trip only on its rising edge.
// [RULE_04] Bit 08 high selects the jog speed setting as reference.
// [RULE_05] Bit 09 selects ramp pair one or two.
// [RULE_06] Bit 10 low makes the whole received word ignored.
// [RULE_07] Bit 11 drives relay 01 only when assigned to it.
// [RULE_08] Bit 12 drives relay 04 only when assigned to it.
// [RULE_09] Bits 14:13 select set-up 1 to 4 under multi set-up mode.
// [RULE_10] Bit 15 reverses only for bus, OR or AND reverse source.
// [RULE_11] Status bit 05 is unused and always zero.
// [RULE_12] Status bit 00 shows control ready, zero when tripped.
// [RULE_13] Status bit 02 zero when motor released, one when start enabled.
// [RULE_14] Status bit 03 holds trip until a reset clears it.
// [RULE_15] Status bits 04, 06, 07 show error, trip lock and warning.
// [RULE_16] Status bit 08 shows speed equal to reference.
// [RULE_17] Status bit 09 zero when local key or local reference site.
// [RULE_18] Status bit 10 one while frequency is strictly inside limits.
// [RULE_19] Status bit 11 shows start signal or nonzero output frequency.
// [RULE_20] Status bits 12 to 15 show overtemp, voltage, torque and thermal timer.
// [RULE_21] Whole status word zero on link loss or internal comms fault.
// [RULE_22] Reference and feedback are 16-bit signed, 0x4000 meaning full scale.
// [RULE_23] Bits 01:00 select one of four preset references.
// [RULE_24] Bit 02 low applies DC braking; high allows ramping.
// [RULE_25] Bit 03 low coasts immediately; high permits starting.
// [RULE_26] Bit 05 low freezes output frequency; only speed up/down inputs change it.
// [RULE_27] A command word is applied as one complete 16-bit value.
module drive_control_status_words
#(
   parameter int WORD_W = 16
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Telegram side: command word and reference from the bus master.
   input wire logic [15:0] driveCommandWord,
   input wire logic signed [15:0] busSpeedRef,
   input wire logic telegramStrobe,
   output logic [15:0] driveStateWord,
   output logic signed [15:0] outputFreqFeedback,
   // Configuration from parameter storage.
   input wire logic signed [15:0] presetRef0,
   input wire logic signed [15:0] presetRef1,
   input wire logic signed [15:0] presetRef2,
   input wire logic signed [15:0] presetRef3,
   input wire logic signed [15:0] jogSpeedSetting,
   input wire logic [1:0] startSourceSelect,
   input wire logic [1:0] reverseSourceSelect,
   input wire logic [1:0] relay1FunctionSelect,
   input wire logic [1:0] relay4FunctionSelect,
   input wire logic multiSetupSelected,
   input wire logic localReferenceSite,
   input wire logic signed [15:0] speedLowLimit,
   input wire logic signed [15:0] speedHighLimit,
   // Digital input functions, already synchronised by the terminal logic.
   input wire logic dinStart,
   input wire logic dinReverse,
   input wire logic dinDcBrake,
   input wire logic dinCoast,
   input wire logic dinResetCoast,
   // Drive state from motion and fault logic.
   input wire logic signed [15:0] actualOutputFreq,
   input wire logic tripEvent,
   input wire logic tripLocked,
   input wire logic errorNoTrip,
   input wire logic warningActive,
   input wire logic powerStageReady,
   input wire logic localStopKey,
   input wire logic overtempStop,
   input wire logic dcLinkOutOfRange,
   input wire logic torqueLimitExceeded,
   input wire logic thermalTimerExceeded,
   input wire logic linkLost,
   input wire logic commFault,
   // Commands to motion, relay and fault logic.
   output logic signed [15:0] speedReference,
   output logic freezeOutput,
   output logic runPermit,
   output logic coastStop,
   output logic dcBrakeStop,
   output logic quickStop,
   output logic rampStop,
   output logic rampSetSecond,
   output logic reverseDir,
   output logic relay1Energise,
   output logic relay4Energise,
   output logic [1:0] activeSetup,
   output logic tripClear
);
   // Elaboration check: the word layout is fixed at 16 bits.
   if (WORD_W != 16)
   begin : gWidthCheck
      $error("drive_control_status_words supports only WORD_W of 16");
   end

   typedef struct packed
   {
      logic [15:0] cmdWord;
      logic signed [15:0] busRef;
      logic tripHeld;
      logic [15:0] stateWord;
      logic signed [15:0] freqFeedback;
      logic signed [15:0] speedRef;
      logic freeze;
      logic runPermit;
      drive_word_pkg::stop_mode_t stopMode;
      logic ramp2;
      logic reverse;
      logic relay1;
      logic relay4;
      logic [1:0] setup;
   } ctrl_state_t;

   ctrl_state_t state_r;
   ctrl_state_t state_nxt;
   logic resetPulse;
   logic validWord;

   // Valid bit of the incoming word decides whether the telegram is taken.
   assign validWord = telegramStrobe & driveCommandWord[drive_word_pkg::CMD_VALID]; // [RULE_06]

   // Trip reset acts on a rising edge across accepted command words.
   trip_reset_edge uResetEdge
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .level(driveCommandWord[drive_word_pkg::CMD_RESET]),
      .sample(validWord),
      .pulse(resetPulse) // [RULE_03]
   );

   // Next-state logic for the command decode and the status word.
   always_comb
   begin
      logic [15:0] cw;
      logic startBus;
      logic startOk;
      logic revOk;
      logic hold;
      logic signed [15:0] baseRef;
      logic [15:0] sw;
      cw = '0;
      startBus = 1'b0;
      startOk = 1'b0;
      revOk = 1'b0;
      hold = 1'b0;
      baseRef = '0;
      sw = '0;
      state_nxt = state_r;
      // Latch the whole word at once, never bit by bit.
      if (validWord)
      begin
         state_nxt.cmdWord = driveCommandWord; // [RULE_27]
         state_nxt.busRef = busSpeedRef; // [RULE_22]
      end
      cw = state_nxt.cmdWord;
      // Trip latch: a new trip wins over a reset in the same cycle.
      if (tripEvent)
      begin
         state_nxt.tripHeld = 1'b1; // [RULE_14]
      end
      else if (resetPulse)
      begin
         state_nxt.tripHeld = 1'b0; // [RULE_14]
      end
      // Start gating by the selected start source: digital input, bus bit, OR or AND.
      startBus = cw[drive_word_pkg::CMD_START];
      case (startSourceSelect)
         drive_word_pkg::START_SRC_DIGITAL: startOk = dinStart;
         drive_word_pkg::START_SRC_BUS: startOk = startBus;
         drive_word_pkg::START_SRC_OR: startOk = startBus | dinStart;
         drive_word_pkg::START_SRC_AND: startOk = startBus & dinStart;
         default: startOk = 1'b0;
      endcase
      hold = ~cw[drive_word_pkg::CMD_HOLD_N]; // [RULE_26]
      // Stop selection by priority; under hold only coast and DC brake stop.
      if (~cw[drive_word_pkg::CMD_COAST_N] | dinCoast | dinResetCoast)
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_COAST; // [RULE_25] [RULE_01]
      end
      else if (~cw[drive_word_pkg::CMD_DC_BRAKE_N] | dinDcBrake)
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_DC_BRAKE; // [RULE_24] [RULE_01]
      end
      else if (hold)
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_NONE; // [RULE_01]
      end
      else if (~cw[drive_word_pkg::CMD_QSTOP_N])
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_QUICK;
      end
      else if (~startOk)
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_RAMP; // [RULE_02]
      end
      else
      begin
         state_nxt.stopMode = drive_word_pkg::STOP_NONE;
      end
      state_nxt.freeze = hold; // [RULE_26]
      state_nxt.runPermit = (state_nxt.stopMode == drive_word_pkg::STOP_NONE)
         & (startOk | hold) & ~state_nxt.tripHeld; // [RULE_02]
      // Reference: jog wins over presets and bus reference.
      case (cw[drive_word_pkg::CMD_PRESET_HI:drive_word_pkg::CMD_PRESET_LO])
         2'h0: baseRef = presetRef0; // [RULE_23]
         2'h1: baseRef = presetRef1; // [RULE_23]
         2'h2: baseRef = presetRef2; // [RULE_23]
         2'h3: baseRef = presetRef3; // [RULE_23]
         default: baseRef = presetRef0;
      endcase
      baseRef = baseRef + state_nxt.busRef; // [RULE_22]
      if (cw[drive_word_pkg::CMD_JOG])
      begin
         state_nxt.speedRef = jogSpeedSetting; // [RULE_04]
      end
      else
      begin
         state_nxt.speedRef = baseRef;
      end
      state_nxt.ramp2 = cw[drive_word_pkg::CMD_RAMP2]; // [RULE_05]
      // Bit 15 reverses only for bus, OR or AND sources; the digital source follows dinReverse.
      case (reverseSourceSelect)
         drive_word_pkg::REV_SRC_DIGITAL: revOk = dinReverse; // [RULE_10]
         drive_word_pkg::REV_SRC_BUS: revOk = cw[drive_word_pkg::CMD_REVERSE]; // [RULE_10]
         drive_word_pkg::REV_SRC_OR: revOk = cw[drive_word_pkg::CMD_REVERSE] | dinReverse;
         drive_word_pkg::REV_SRC_AND: revOk = cw[drive_word_pkg::CMD_REVERSE] & dinReverse;
         default: revOk = 1'b0;
      endcase
      state_nxt.reverse = revOk;
      state_nxt.relay1 = cw[drive_word_pkg::CMD_RELAY1]
         & (relay1FunctionSelect == drive_word_pkg::RELAY_SEL_CMD11); // [RULE_07]
      state_nxt.relay4 = cw[drive_word_pkg::CMD_RELAY4]
         & (relay4FunctionSelect == drive_word_pkg::RELAY_SEL_CMD12); // [RULE_08]
      if (multiSetupSelected)
      begin
         state_nxt.setup =
            cw[drive_word_pkg::CMD_SETUP_HI:drive_word_pkg::CMD_SETUP_LO]; // [RULE_09]
      end
      // Status word built from the drive's live state.
      sw[drive_word_pkg::ST_CTRL_READY] = ~state_nxt.tripHeld; // [RULE_12]
      sw[drive_word_pkg::ST_DRIVE_READY] = ~state_nxt.tripHeld & powerStageReady;
      sw[drive_word_pkg::ST_ENABLE] = (state_nxt.stopMode != drive_word_pkg::STOP_COAST)
         & ~state_nxt.tripHeld; // [RULE_13]
      sw[drive_word_pkg::ST_TRIP] = state_nxt.tripHeld; // [RULE_14]
      sw[drive_word_pkg::ST_ERROR] = errorNoTrip; // [RULE_15]
      sw[drive_word_pkg::ST_UNUSED] = 1'b0; // [RULE_11]
      sw[drive_word_pkg::ST_TRIPLOCK] = tripLocked; // [RULE_15]
      sw[drive_word_pkg::ST_WARNING] = warningActive; // [RULE_15]
      sw[drive_word_pkg::ST_AT_REF] = (actualOutputFreq == state_r.speedRef); // [RULE_16]
      sw[drive_word_pkg::ST_BUS_CTRL] = ~(localStopKey | localReferenceSite); // [RULE_17]
      sw[drive_word_pkg::ST_IN_LIMIT] = (actualOutputFreq > speedLowLimit)
         & (actualOutputFreq < speedHighLimit); // [RULE_18]
      sw[drive_word_pkg::ST_RUNNING] = startOk | (actualOutputFreq != 16'sh0000); // [RULE_19]
      sw[drive_word_pkg::ST_OVERTEMP] = overtempStop; // [RULE_20]
      sw[drive_word_pkg::ST_VOLTAGE] = dcLinkOutOfRange; // [RULE_20]
      sw[drive_word_pkg::ST_TORQUE] = torqueLimitExceeded; // [RULE_20]
      sw[drive_word_pkg::ST_TIMER] = thermalTimerExceeded; // [RULE_20]
      if (linkLost | commFault)
      begin
         sw = drive_word_pkg::STATUS_RESET_VALUE; // [RULE_21]
      end
      state_nxt.stateWord = sw;
      state_nxt.freqFeedback = actualOutputFreq; // [RULE_22]
   end

   // State register; command word resets to all-stop with coast active.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= '0;
         state_r.cmdWord <= drive_word_pkg::CMD_RESET_VALUE;
         state_r.stopMode <= drive_word_pkg::STOP_COAST;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state register, tripClear from the edge detector; stop outputs are bits of the one-hot stop code.
   assign driveStateWord = state_r.stateWord;
   assign outputFreqFeedback = state_r.freqFeedback;
   assign speedReference = state_r.speedRef;
   assign freezeOutput = state_r.freeze;
   assign runPermit = state_r.runPermit;
   assign coastStop = state_r.stopMode[1];
   assign dcBrakeStop = state_r.stopMode[2];
   assign quickStop = state_r.stopMode[3];
   assign rampStop = state_r.stopMode[4];
   assign rampSetSecond = state_r.ramp2;
   assign reverseDir = state_r.reverse;
   assign relay1Energise = state_r.relay1;
   assign relay4Energise = state_r.relay4;
   assign activeSetup = state_r.setup;
   assign tripClear = resetPulse;
endmodule // drive_control_status_words

// ==== core/drive_word_pkg.sv ====
// Package with the field positions, encodings and reset values of the drive command and status words.
package drive_word_pkg;
   // Command word bit positions.
   localparam int CMD_PRESET_LO = 0;
   localparam int CMD_PRESET_HI = 1;
   localparam int CMD_DC_BRAKE_N = 2;
   localparam int CMD_COAST_N = 3;
   localparam int CMD_QSTOP_N = 4;
   localparam int CMD_HOLD_N = 5;
   localparam int CMD_START = 6;
   localparam int CMD_RESET = 7;
   localparam int CMD_JOG = 8;
   localparam int CMD_RAMP2 = 9;
   localparam int CMD_VALID = 10;
   localparam int CMD_RELAY1 = 11;
   localparam int CMD_RELAY4 = 12;
   localparam int CMD_SETUP_LO = 13;
   localparam int CMD_SETUP_HI = 14;
   localparam int CMD_REVERSE = 15;
   // Status word bit positions.
   localparam int ST_CTRL_READY = 0;
   localparam int ST_DRIVE_READY = 1;
   localparam int ST_ENABLE = 2;
   localparam int ST_TRIP = 3;
   localparam int ST_ERROR = 4;
   localparam int ST_UNUSED = 5;
   localparam int ST_TRIPLOCK = 6;
   localparam int ST_WARNING = 7;
   localparam int ST_AT_REF = 8;
   localparam int ST_BUS_CTRL = 9;
   localparam int ST_IN_LIMIT = 10;
   localparam int ST_RUNNING = 11;
   localparam int ST_OVERTEMP = 12;
   localparam int ST_VOLTAGE = 13;
   localparam int ST_TORQUE = 14;
   localparam int ST_TIMER = 15;
   // Relative reference scaling: this code means 100 percent.
   localparam logic signed [15:0] REF_FULL_SCALE = 16'sh4000;
   // Word reset values: command word resets to an all-stop word.
   localparam logic [15:0] CMD_RESET_VALUE = 16'h0000;
   localparam logic [15:0] STATUS_RESET_VALUE = 16'h0000;
   // Relay function selections.
   localparam logic [1:0] RELAY_SEL_OTHER = 2'h0;
   localparam logic [1:0] RELAY_SEL_CMD11 = 2'h1;
   localparam logic [1:0] RELAY_SEL_CMD12 = 2'h2;
   // Reverse source selections.
   localparam logic [1:0] REV_SRC_DIGITAL = 2'h0;
   localparam logic [1:0] REV_SRC_BUS = 2'h1;
   localparam logic [1:0] REV_SRC_OR = 2'h2;
   localparam logic [1:0] REV_SRC_AND = 2'h3;
   // Start source selections.
   localparam logic [1:0] START_SRC_DIGITAL = 2'h0;
   localparam logic [1:0] START_SRC_BUS = 2'h1;
   localparam logic [1:0] START_SRC_OR = 2'h2;
   localparam logic [1:0] START_SRC_AND = 2'h3;
   // Stop mode encodings, one-hot.
   typedef enum logic [4:0] {
      STOP_NONE = 5'b00001,
      STOP_COAST = 5'b00010,
      STOP_DC_BRAKE = 5'b00100,
      STOP_QUICK = 5'b01000,
      STOP_RAMP = 5'b10000
   } stop_mode_t;
endpackage

// ==== core/trip_reset_edge.sv ====
// Module that turns a qualified reset level into a one-cycle pulse on its rising edge.
`timescale 1ns/1ps
module trip_reset_edge
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Level in and pulse out.
   input wire logic level,
   input wire logic sample,
   output logic pulse
);
   typedef struct packed
   {
      logic prev;
      logic pulse;
   } edge_state_t;

   edge_state_t state_r;
   edge_state_t state_nxt;

   // A pulse comes only when a new sample shows a 0 to 1 change.
   always_comb
   begin
      state_nxt = state_r;
      state_nxt.pulse = 1'b0;
      if (sample)
      begin
         state_nxt.pulse = level & ~state_r.prev; // [RULE_03]
         state_nxt.prev = level;
      end
   end

   // State register.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign pulse = state_r.pulse;
endmodule // trip_reset_edge

// ==== dv/drive_control_status_words_assertions.sv ====
// Checker for the drive command and status word block, bound to its ports.
`timescale 1ns/1ps
module drive_control_status_words_assertions
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic nrst,
   // Telegram, configuration and drive state inputs.
   input wire logic [15:0] driveCommandWord,
   input wire logic telegramStrobe,
   input wire logic signed [15:0] jogSpeedSetting,
   input wire logic [1:0] relay1FunctionSelect,
   input wire logic [1:0] relay4FunctionSelect,
   input wire logic multiSetupSelected,
   input wire logic tripEvent,
   input wire logic warningActive,
   input wire logic linkLost,
   input wire logic commFault,
   // Watched outputs.
   input wire logic [15:0] driveStateWord,
   input wire logic signed [15:0] speedReference,
   input wire logic coastStop,
   input wire logic rampSetSecond,
   input wire logic relay1Energise,
   input wire logic relay4Energise,
   input wire logic [1:0] activeSetup,
   input wire logic tripClear
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic taken;
   logic lastReset_r;
   logic linkOk;
   // A word counts only when strobed with its valid bit set.
   assign taken = telegramStrobe && driveCommandWord[10];
   assign linkOk = !linkLost && !commFault;
   // Remembers the reset bit of the last accepted word, so edges are judged between words.
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         lastReset_r <= 1'b0;
      else if (taken)
         lastReset_r <= driveCommandWord[7];
   end
   a_invalid_ignored: assert property (
      telegramStrobe && !driveCommandWord[10] |=> $stable(rampSetSecond))
      else $error("word without valid bit changed the ramp pair");
   a_ramp_pair: assert property (
      taken |=> rampSetSecond == $past(driveCommandWord[9]))
      else $error("ramp pair does not follow the accepted word");
   a_relay_one: assert property (
      taken && relay1FunctionSelect == drive_word_pkg::RELAY_SEL_CMD11
      |=> relay1Energise == $past(driveCommandWord[11]))
      else $error("relay one does not follow its command bit");
   a_relay_four: assert property (
      taken && relay4FunctionSelect == drive_word_pkg::RELAY_SEL_CMD12
      |=> relay4Energise == $past(driveCommandWord[12]))
      else $error("relay four does not follow its command bit");
   a_setup_select: assert property (
      taken && multiSetupSelected |=> activeSetup == $past(driveCommandWord[14:13]))
      else $error("active set-up does not follow the accepted word");
   a_jog_ref: assert property (
      taken && driveCommandWord[8] |=> speedReference == $past(jogSpeedSetting))
      else $error("jog word did not select the jog speed");
   a_coast_now: assert property (
      taken && !driveCommandWord[3] |=> coastStop)
      else $error("coast word did not release the motor");
   a_spare_bit: assert property (!driveStateWord[5])
      else $error("unused status bit is set");
   a_link_lost: assert property (
      !linkOk |=> driveStateWord == 16'h0000)
      else $error("status word not cleared on link loss");
   a_trip_flag: assert property (
      tripEvent && linkOk |=> driveStateWord[3] && !driveStateWord[0])
      else $error("trip not shown in status word");
   a_warn_flag: assert property (
      warningActive && linkOk |=> driveStateWord[7])
      else $error("warning not shown in status word");
   a_reset_edge: assert property (
      taken && driveCommandWord[7] && !lastReset_r && !tripEvent |-> ##[1:2] tripClear)
      else $error("rising reset bit gave no trip clear");
   // Main scenarios.
   c_reset_edge: cover property (taken && driveCommandWord[7] && !lastReset_r);
   c_jog: cover property (taken && driveCommandWord[8]);
   c_link_lost: cover property (linkLost);
endmodule // drive_control_status_words_assertions

// ==== dv/bus_master_model.sv ====
// Fieldbus master model that sends command telegrams with a speed reference.
`timescale 1ns/1ps
module bus_master_model
(
   // Clock.
   input wire logic clk_sys,
   // Telegram lines.
   output logic [15:0] driveCommandWord,
   output logic signed [15:0] busSpeedRef,
   output logic telegramStrobe
);
   // Lines start quiet.
   initial
   begin
      driveCommandWord = 16'h0000;
      busSpeedRef = 16'sh0000;
      telegramStrobe = 1'b0;
   end
   // One telegram: whole word and reference together for one strobe cycle.
   task automatic send(input logic [15:0] word, input logic signed [15:0] refVal);
      @(negedge clk_sys);
      driveCommandWord = word;
      busSpeedRef = refVal;
      telegramStrobe = 1'b1;
      @(negedge clk_sys);
      telegramStrobe = 1'b0;
      // Stale lines are inverted so an unstrobed word is never mistaken for the last one.
      driveCommandWord = ~word;
      busSpeedRef = ~refVal;
   endtask
endmodule // bus_master_model

// ==== dv/tb.sv ====
// Self-checking testbench for the drive command and status word block.
`timescale 1ns/1ps
module tb;
   logic clk_sys, nrst, telegramStrobe, multiSetupSelected, localReferenceSite, dinStart;
   logic dinReverse, dinDcBrake, dinCoast, dinResetCoast, tripEvent, powerStageReady;
   logic localStopKey, linkLost, commFault, freezeOutput, runPermit, coastStop, dcBrakeStop;
   logic quickStop, rampStop, rampSetSecond, reverseDir, relay1Energise, relay4Energise, tripClear;
   logic [15:0] driveCommandWord, driveStateWord;
   logic signed [15:0] busSpeedRef, outputFreqFeedback, jogSpeedSetting, speedLowLimit;
   logic signed [15:0] speedHighLimit, actualOutputFreq, speedReference;
   logic signed [15:0] preset [4];
   logic [1:0] startSourceSelect, reverseSourceSelect, relay1FunctionSelect;
   logic [1:0] relay4FunctionSelect, activeSetup;
   logic [6:0] flags;
   int n_errors, n_checks, nPulse, cycles;
   int pos [7] = '{4, 6, 7, 12, 13, 14, 15};
   logic [15:0] stopWord [5] = '{16'h047C, 16'h043C, 16'h0478, 16'h0474, 16'h041C};
   logic [3:0] stopExp [5] = '{4'b0000, 4'b1000, 4'b0100, 4'b0010, 4'b0001};
   logic [3:0] revExp = 4'b0110;
   bus_master_model u_master (.clk_sys, .driveCommandWord, .busSpeedRef, .telegramStrobe);
   drive_control_status_words u_dut (.clk_sys, .nrst, .driveCommandWord, .busSpeedRef,
      .telegramStrobe, .driveStateWord, .outputFreqFeedback, .presetRef0(preset[0]),
      .presetRef1(preset[1]), .presetRef2(preset[2]), .presetRef3(preset[3]), .jogSpeedSetting,
      .startSourceSelect, .reverseSourceSelect, .relay1FunctionSelect, .relay4FunctionSelect,
      .multiSetupSelected, .localReferenceSite, .speedLowLimit, .speedHighLimit, .dinStart,
      .dinReverse, .dinDcBrake, .dinCoast, .dinResetCoast, .actualOutputFreq, .tripEvent,
      .tripLocked(flags[1]), .errorNoTrip(flags[0]), .warningActive(flags[2]), .powerStageReady,
      .localStopKey, .overtempStop(flags[3]), .dcLinkOutOfRange(flags[4]),
      .torqueLimitExceeded(flags[5]), .thermalTimerExceeded(flags[6]), .linkLost, .commFault,
      .speedReference, .freezeOutput, .runPermit, .coastStop, .dcBrakeStop, .quickStop,
      .rampStop, .rampSetSecond, .reverseDir, .relay1Energise, .relay4Energise, .activeSetup,
      .tripClear);
   // Free-running clock at 100 MHz.
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Counts trip clear pulses and cuts a hang short.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (tripClear === 1'b1)
         nPulse++;
      if (cycles == 3000)
      begin
         n_errors++;
         stop_test();
      end
   end
   // Compares one value and reports a mismatch.
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Waits n rising edges, then returns at the next falling edge.
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic send(input logic [15:0] w);
      u_master.send(w, 16'sh0000);
      tick(2);
   endtask
   task automatic stop_test();
      $display("TB: checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      nrst = 1'b0;
      {multiSetupSelected, localReferenceSite, dinStart, dinReverse, dinDcBrake} = '0;
      {dinCoast, dinResetCoast, tripEvent, localStopKey, linkLost, commFault} = '0;
      powerStageReady = 1'b1;
      flags = '0;
      preset = '{16'sh0400, 16'sh0800, -16'sh0400, 16'sh4000};
      jogSpeedSetting = 16'sh1234;
      {speedLowLimit, speedHighLimit, actualOutputFreq} = {16'sh0000, 16'sh4000, 16'sh2000};
      startSourceSelect = drive_word_pkg::START_SRC_BUS;
      reverseSourceSelect = drive_word_pkg::REV_SRC_DIGITAL;
      relay1FunctionSelect = drive_word_pkg::RELAY_SEL_CMD11;
      relay4FunctionSelect = drive_word_pkg::RELAY_SEL_OTHER;
      tick(2);
      chk("coast in reset", 16'h1, 16'(coastStop));
      chk("status in reset", 16'h0000, driveStateWord);
      nrst = 1'b1;
      send(16'h047C);
      chk("run permit", 16'h1, 16'(runPermit));
      send(16'h0074);
      chk("invalid word", 16'h0, 16'(coastStop));
      for (int i = 0; i < 5; i++)
      begin
         send(stopWord[i]);
         chk("stops", 16'(stopExp[i]),
            {rampStop, dcBrakeStop, coastStop, freezeOutput});
      end
      send(16'h046C);
      chk("quick stop", 16'h3, {quickStop, driveStateWord[2]});
      send(16'h0474);
      chk("coast status", 16'h0, {quickStop, driveStateWord[2]});
      $display("TB: test stops finished");
      for (int i = 0; i < 4; i++)
      begin
         send(16'h047C | 16'(i));
         chk("preset", preset[i], speedReference);
      end
      send(16'h057C);
      chk("jog", jogSpeedSetting, speedReference);
      send(16'h1E7C);
      chk("ramp relays", 16'h5,
         {rampSetSecond, relay4Energise, relay1Energise});
      relay4FunctionSelect = drive_word_pkg::RELAY_SEL_CMD12;
      send(16'h147C);
      chk("relays", 16'h2, {rampSetSecond, relay4Energise, relay1Energise});
      multiSetupSelected = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         send(16'h047C | (16'(i) << 13));
         chk("setup", 16'(i), 16'(activeSetup));
      end
      for (int s = 0; s < 4; s++)
      begin
         reverseSourceSelect = 2'(s);
         send(16'hC47C);
         chk("reverse", 16'(revExp[s]), 16'(reverseDir));
      end
      $display("TB: test command bits finished");
      tripEvent = 1'b1;
      tick(1);
      tripEvent = 1'b0;
      tick(2);
      chk("trip", 16'h1, {driveStateWord[0], driveStateWord[3]});
      nPulse = 0;
      send(16'h04FC);
      tick(1);
      chk("clear pulses", 16'h1, 16'(nPulse));
      chk("trip cleared", 16'h0, 16'(driveStateWord[3]));
      send(16'h04FC);
      tick(1);
      chk("steady reset", 16'h1, 16'(nPulse));
      for (int i = 0; i < 7; i++)
      begin
         flags = 7'(1 << i);
         tick(2);
         chk("flag", 16'h2,
            {driveStateWord[pos[i]], driveStateWord[5]});
      end
      flags = 7'h7F;
      linkLost = 1'b1;
      tick(2);
      chk("link lost", 16'h0000, driveStateWord);
      {linkLost, commFault} = 2'b01;
      tick(2);
      chk("comm fault", 16'h0000, driveStateWord);
      {commFault, flags} = '0;
      tick(2);
      chk("in limit", 16'h0E07, driveStateWord);
      chk("feedback", 16'h2000, outputFreqFeedback);
      {actualOutputFreq, localStopKey} = {16'sh4000, 1'b1};
      tick(2);
      chk("at limit", 16'h4, {driveStateWord[11:9]});
      {localStopKey, localReferenceSite} = 2'b01;
      tick(2);
      chk("local site", 16'h0, 16'(driveStateWord[9]));
      actualOutputFreq = preset[0];
      tick(2);
      chk("at ref", 16'h1, 16'(driveStateWord[8]));
      $display("TB: test status word finished");
      stop_test();
   end
endmodule // tb
bind drive_control_status_words drive_control_status_words_assertions u_chk (.clk_sys, .nrst,
   .driveCommandWord, .telegramStrobe, .jogSpeedSetting, .relay1FunctionSelect,
   .relay4FunctionSelect, .multiSetupSelected, .tripEvent, .warningActive, .linkLost,
   .commFault, .driveStateWord, .speedReference, .coastStop, .rampSetSecond, .relay1Energise,
   .relay4Energise, .activeSetup, .tripClear);
